// File: shared/usu_pkg.sv
// Purpose: shared constants and types of the universal shift unit
// Assumes: included by usu_top and tb through an import of the whole package
// Notes: widths are fixed; nothing here is tunable at build time
package usu_pkg;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int USU_SR_W = 8;
  localparam int USU_CNT_W = 4;
  localparam logic [7:0] USU_SR_RESET = 8'h00;
  localparam logic [3:0] USU_CNT_RESET = 4'h0;
  localparam logic [3:0] USU_CNT_MAX = 4'hf;
  localparam logic [3:0] USU_CNT_STEP = 4'h1;

  // ***************************************************************
  // wire modes
  // ***************************************************************
  localparam logic [1:0] USU_WM_OFF = 2'h0;
  localparam logic [1:0] USU_WM_THREE = 2'h1;
  localparam logic [1:0] USU_WM_TWO = 2'h2;
  localparam logic [1:0] USU_WM_TWO_HOLD = 2'h3;

  // ***************************************************************
  // shift clock source, one-hot
  // ***************************************************************
  typedef enum logic [3:0] {
    USU_SRC_NONE = 4'h1,
    USU_SRC_STROBE = 4'h2,
    USU_SRC_TIMER = 4'h4,
    USU_SRC_EXT = 4'h8
  } usu_src_t;

endpackage : usu_pkg

// File: src/usu_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes: q follows only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module usu_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
    end
  end

endmodule : usu_sync3
`default_nettype wire

// File: src/usu_link_edge.sv
// Purpose: captures the data input on both edges of the shift clock pin
// Assumes: link_clk is the shift clock pin itself; it may stop between bytes
// Notes: each edge flips its own toggle, so the core sees one event per edge
`timescale 1ns/100ps
`default_nettype none
module usu_link_edge (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic data_in,
  output logic rise_tog_q,
  output logic rise_bit_q,
  output logic fall_tog_q,
  output logic fall_bit_q
);

  // ***************************************************************
  // rising edge capture
  // ***************************************************************
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      rise_tog_q <= 1'b0;
      rise_bit_q <= 1'b0;
    end else begin
      rise_tog_q <= ~rise_tog_q;
      rise_bit_q <= data_in;
    end
  end

  // ***************************************************************
  // falling edge capture
  // ***************************************************************
  always_ff @(negedge link_clk or negedge resetn) begin
    if (!resetn) begin
      fall_tog_q <= 1'b0;
      fall_bit_q <= 1'b0;
    end else begin
      fall_tog_q <= ~fall_tog_q;
      fall_bit_q <= data_in;
    end
  end

endmodule : usu_link_edge
`default_nettype wire

// File: src/usu_top.sv
// Purpose: universal shift unit, shift register, edge counter and clock control
// Assumes: pin clock edges at least eight core cycles apart
// Notes:
`timescale 1ns/100ps
`default_nettype none
module usu_top
  import usu_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic shift_clock_pin,
  input wire logic serial_data_in,
  input wire logic timer_compare,
  input wire logic ctrl_wr,
  input wire logic [1:0] ctrl_wire_mode,
  input wire logic ctrl_clock_edge_select,
  input wire logic ctrl_external_clock_select,
  input wire logic ctrl_software_clock_strobe,
  input wire logic ctrl_clock_pin_toggle,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic status_wr,
  input wire logic status_overflow_clear,
  input wire logic status_start_clear,
  input wire logic [3:0] status_counter_wdata,
  input wire logic port_clock_dir,
  input wire logic port_data_dir,
  input wire logic overflow_int_en,
  input wire logic start_int_en,
  output logic [7:0] shift_data_register_q,
  output logic [3:0] counter_q,
  output logic counter_overflow_flag_q,
  output logic start_flag_q,
  output logic overflow_irq_q,
  output logic start_irq_q,
  output logic data_out_q,
  output logic data_out_oe_n_q,
  output logic sda_oe_n_q,
  output logic shift_clock_out_q,
  output logic shift_clock_oe_n_q
);

  // ***************************************************************
  // configuration
  // ***************************************************************
  logic [1:0] wire_mode_q;
  logic edge_sel_q;
  logic ext_sel_q;
  logic strobe_sel_q;
  logic clk_out_q;
  logic latch_q;
  logic scl_hold_q;
  usu_src_t src;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wire_mode_q <= USU_WM_OFF;
      edge_sel_q <= 1'b0;
      ext_sel_q <= 1'b0;
      strobe_sel_q <= 1'b0;
    end else if (ctrl_wr) begin
      wire_mode_q <= ctrl_wire_mode;
      edge_sel_q <= ctrl_clock_edge_select;
      ext_sel_q <= ctrl_external_clock_select;
      strobe_sel_q <= ctrl_software_clock_strobe;
    end
  end

  logic two_wire;
  logic master;
  logic tog;
  logic strobe;
  assign two_wire = wire_mode_q[1];
  assign master = port_clock_dir;
  assign tog = ctrl_wr & ctrl_clock_pin_toggle;
  assign strobe = ctrl_wr & ctrl_software_clock_strobe;

  // three sources: pin, timer match, software strobe
  always_comb begin
    if (ext_sel_q) begin
      src = USU_SRC_EXT;
    end else if (edge_sel_q) begin
      src = USU_SRC_TIMER;
    end else if (strobe_sel_q | strobe) begin
      // the strobe bit acts in its own write, not only once stored
      src = USU_SRC_STROBE;
    end else begin
      src = USU_SRC_NONE;
    end
  end

  // ***************************************************************
  // pin side crossing
  // ***************************************************************
  logic rise_tog;
  logic rise_bit;
  logic fall_tog;
  logic fall_bit;
  logic [5:0] xs_q;
  logic [1:0] tog_prev_q;
  logic [1:0] lvl_q;
  logic sda_prev_q;

  usu_link_edge u_link (
    .link_clk(shift_clock_pin),
    .resetn(resetn),
    .data_in(serial_data_in),
    .rise_tog_q(rise_tog),
    .rise_bit_q(rise_bit),
    .fall_tog_q(fall_tog),
    .fall_bit_q(fall_bit)
  );

  // toggles, captured bits and raw pin levels share one synchroniser
  usu_sync3 #(.W(6)) u_sync (
    .clk(core_clk),
    .resetn(resetn),
    .d({rise_tog, rise_bit, fall_tog, fall_bit, shift_clock_pin, serial_data_in}),
    .q(xs_q)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tog_prev_q <= 2'h0;
      lvl_q <= 2'h0;
      sda_prev_q <= 1'b0;
    end else begin
      tog_prev_q <= {xs_q[5], xs_q[3]};
      lvl_q <= xs_q[1:0];
      sda_prev_q <= lvl_q[0];
    end
  end

  logic scl_lvl;
  logic sda_lvl;
  logic pin_rise;
  logic pin_fall;
  logic pin_bit;
  logic clk_lvl;
  assign scl_lvl = lvl_q[1];
  assign sda_lvl = lvl_q[0];
  // a master sees its own toggles directly, a slave sees the pin
  assign pin_rise = master ? (tog & ~clk_out_q) : (xs_q[5] ^ tog_prev_q[1]);
  assign pin_fall = master ? (tog & clk_out_q) : (xs_q[3] ^ tog_prev_q[0]);
  assign pin_bit = master ? sda_lvl : (edge_sel_q ? xs_q[2] : xs_q[4]);
  assign clk_lvl = master ? clk_out_q : scl_lvl;

  // ***************************************************************
  // clock events
  // ***************************************************************
  logic shift_en;
  logic count_en;
  logic shift_bit;

  always_comb begin
    shift_en = 1'b0;
    count_en = 1'b0;
    shift_bit = sda_lvl;
    case (src)
      USU_SRC_EXT: begin
        shift_en = edge_sel_q ? pin_fall : pin_rise;
        shift_bit = pin_bit;
        count_en = strobe_sel_q ? tog : (pin_rise | pin_fall);
      end
      USU_SRC_TIMER: begin
        shift_en = timer_compare;
        count_en = timer_compare;
      end
      USU_SRC_STROBE: begin
        shift_en = strobe;
        count_en = strobe;
      end
      USU_SRC_NONE: begin
        shift_en = 1'b0;
        count_en = 1'b0;
      end
      default: begin
        shift_en = 1'b0;
        count_en = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // shift register and counter
  // ***************************************************************
  // no receive buffer: a write during a byte overwrites it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_data_register_q <= USU_SR_RESET;
    end else if (data_wr) begin
      shift_data_register_q <= data_wdata;
    end else if (shift_en) begin
      shift_data_register_q <= {shift_data_register_q[6:0], shift_bit};
    end
  end

  logic ovf_evt;
  assign ovf_evt = count_en & (counter_q == USU_CNT_MAX);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter_q <= USU_CNT_RESET;
    end else if (status_wr) begin
      counter_q <= status_counter_wdata;
    end else if (count_en) begin
      counter_q <= counter_q + USU_CNT_STEP;
    end
  end

  // an overflow in the clearing cycle survives
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter_overflow_flag_q <= 1'b0;
    end else if (ovf_evt) begin
      counter_overflow_flag_q <= 1'b1;
    end else if (status_wr && status_overflow_clear) begin
      counter_overflow_flag_q <= 1'b0;
    end
  end

  // ***************************************************************
  // start detector and clock hold
  // ***************************************************************
  logic start_evt;
  logic hold_d;
  assign start_evt = two_wire & scl_lvl & sda_prev_q & ~sda_lvl;
  assign hold_d = two_wire & (scl_hold_q | ~scl_lvl)
    & (start_flag_q | ((wire_mode_q == USU_WM_TWO_HOLD) & counter_overflow_flag_q));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_flag_q <= 1'b0;
    end else if (start_evt) begin
      start_flag_q <= 1'b1;
    end else if (status_wr && status_start_clear) begin
      start_flag_q <= 1'b0;
    end
  end

  // hold starts only once the master has pulled the clock low itself
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_hold_q <= 1'b0;
    end else begin
      scl_hold_q <= hold_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_irq_q <= 1'b0;
      start_irq_q <= 1'b0;
    end else begin
      overflow_irq_q <= counter_overflow_flag_q & overflow_int_en;
      start_irq_q <= start_flag_q & start_int_en & two_wire;
    end
  end

  // ***************************************************************
  // clock pin
  // ***************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_out_q <= 1'b0;
    end else if (tog) begin
      clk_out_q <= ~clk_out_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_clock_out_q <= 1'b0;
      shift_clock_oe_n_q <= 1'b1;
    end else begin
      shift_clock_out_q <= clk_out_q & ~hold_d;
      shift_clock_oe_n_q <= ~(port_clock_dir | hold_d);
    end
  end

  // ***************************************************************
  // output latch and data pins
  // ***************************************************************
  logic latch_open;
  // always open off the pin clock; on the pin clock, open while it rests in the output phase
  assign latch_open = (src != USU_SRC_EXT) | (clk_lvl == edge_sel_q);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (latch_open) begin
      latch_q <= shift_data_register_q[USU_SR_W-1];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_out_q <= 1'b0;
      data_out_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      data_out_q <= latch_q;
      data_out_oe_n_q <= ~(port_data_dir & (wire_mode_q == USU_WM_THREE));
      sda_oe_n_q <= ~(port_data_dir & two_wire & ~latch_q);
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_start_seen;
    start_evt ##1 start_flag_q;
  endsequence

  sequence s_clock_low;
    !scl_lvl && two_wire && !status_wr;
  endsequence

  a_ovf_sets: assert property (
    ovf_evt |=> counter_overflow_flag_q && (counter_q == USU_CNT_RESET || $past(status_wr))
  ) else $error("overflow flag not set on wrap");

  a_ovf_clear: assert property (
    status_wr && status_overflow_clear && !ovf_evt
      |=> !counter_overflow_flag_q && counter_q == $past(status_counter_wdata)
  ) else $error("status write did not clear flag and load counter");

  a_shift_hold: assert property (
    !shift_en && !data_wr |=> $stable(shift_data_register_q)
  ) else $error("shift register moved without a clock event");

  a_shift_in: assert property (
    shift_en && !data_wr
      |=> shift_data_register_q == {$past(shift_data_register_q[6:0]), $past(shift_bit)}
  ) else $error("shift did not take the input bit");

  a_count_step: assert property (
    count_en && !status_wr |=> counter_q == $past(counter_q) + USU_CNT_STEP
  ) else $error("counter did not step with the clock event");

  a_strobe_toggle: assert property (
    tog |=> clk_out_q != $past(clk_out_q)
  ) else $error("toggle write did not flip the clock pin");

  a_start_flag: assert property (
    start_evt |-> s_start_seen
  ) else $error("start condition did not set the flag");

  a_start_hold: assert property (
    start_flag_q ##0 s_clock_low |=> !shift_clock_oe_n_q && !shift_clock_out_q
  ) else $error("clock not held low after start");

  a_idle_wake: assert property (
    counter_overflow_flag_q && overflow_int_en |=> overflow_irq_q
  ) else $error("overflow did not raise the wake request");

  a_latch_closed: assert property (
    !latch_open |=> $stable(latch_q)
  ) else $error("output latch changed while closed");

endmodule : usu_top
`default_nettype wire

// File: sim/usu_spi_master.sv
// Purpose: spi mode 0 or 1 master model facing the shift unit as slave
// Assumes: link_clk is the free 30 ns bench clock
// Notes: sck rests low between frames; half period given per call
`timescale 1ns/100ps
`default_nettype none
module usu_spi_master (
  input wire logic link_clk,
  input wire logic miso,
  output logic sck,
  output logic mosi
);
  // ****
  // frame engine
  // ****
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
  end

  task automatic xfer(input logic [7:0] tx, input int half, input logic cpha,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      @(posedge link_clk);
      mosi <= tx[i]; // set up half a period ahead
      if (cpha) begin
        sck <= 1'b1; // mode 1 sets up on the leading edge
      end
      repeat (half) @(posedge link_clk);
      rx = {rx[6:0], miso}; // sample on the sampling edge
      sck <= ~cpha;
      repeat (half) @(posedge link_clk);
      sck <= 1'b0;
    end
    @(posedge link_clk);
    mosi <= ~mosi; // line flipped to the inverse bit, so no stale bit is left on it
  endtask : xfer
endmodule : usu_spi_master
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench of the universal shift unit
// Assumes: inputs move 2 ns after core edges; pin edges stay 800 ns apart
// Notes: expected register and counter live in integer model variables, the flag in exp_flag
`timescale 1ns/100ps
`default_nettype none
module tb
  import usu_pkg::*;
();
  // ****
  // signals and helpers
  // ****
  logic core_clk, link_clk, resetn, timer_compare, ctrl_wr, ctrl_clock_edge_select;
  logic ctrl_external_clock_select, ctrl_software_clock_strobe, ctrl_clock_pin_toggle;
  logic data_wr, status_wr, status_overflow_clear, status_start_clear, port_clock_dir;
  logic port_data_dir, overflow_int_en, start_int_en, tb_own, tb_scl, tb_di, exp_clk;
  logic [1:0] ctrl_wire_mode;
  logic [7:0] data_wdata, shift_data_register_q, txd, txm, rx;
  logic [3:0] status_counter_wdata, counter_q;
  logic counter_overflow_flag_q, start_flag_q, overflow_irq_q, start_irq_q, data_out_q;
  logic data_out_oe_n_q, sda_oe_n_q, shift_clock_out_q, shift_clock_oe_n_q, m_sck, m_mosi;
  logic exp_flag;
  int exp_sr, exp_cnt, n_mismatch, tests_run, seed;
  wire logic clk_wire;
  wire logic di_wire;
  wire logic miso_wire;
  // undriven lines show a changing pattern, never a stale bit
  assign clk_wire = !shift_clock_oe_n_q ? shift_clock_out_q : (tb_own ? tb_scl : m_sck);
  assign di_wire = !sda_oe_n_q ? 1'b0 : (tb_own ? tb_di : m_mosi);
  assign miso_wire = data_out_oe_n_q ? link_clk : data_out_q;

  usu_top u_dut (.core_clk(core_clk), .resetn(resetn), .shift_clock_pin(clk_wire),
    .serial_data_in(di_wire), .timer_compare(timer_compare), .ctrl_wr(ctrl_wr),
    .ctrl_wire_mode(ctrl_wire_mode), .ctrl_clock_edge_select(ctrl_clock_edge_select),
    .ctrl_external_clock_select(ctrl_external_clock_select),
    .ctrl_software_clock_strobe(ctrl_software_clock_strobe),
    .ctrl_clock_pin_toggle(ctrl_clock_pin_toggle), .data_wr(data_wr),
    .data_wdata(data_wdata), .status_wr(status_wr),
    .status_overflow_clear(status_overflow_clear), .status_start_clear(status_start_clear),
    .status_counter_wdata(status_counter_wdata), .port_clock_dir(port_clock_dir),
    .port_data_dir(port_data_dir), .overflow_int_en(overflow_int_en),
    .start_int_en(start_int_en), .shift_data_register_q(shift_data_register_q),
    .counter_q(counter_q), .counter_overflow_flag_q(counter_overflow_flag_q),
    .start_flag_q(start_flag_q), .overflow_irq_q(overflow_irq_q),
    .start_irq_q(start_irq_q), .data_out_q(data_out_q), .data_out_oe_n_q(data_out_oe_n_q),
    .sda_oe_n_q(sda_oe_n_q), .shift_clock_out_q(shift_clock_out_q),
    .shift_clock_oe_n_q(shift_clock_oe_n_q));

  usu_spi_master u_master (.link_clk(link_clk), .miso(miso_wire), .sck(m_sck),
    .mosi(m_mosi));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_model();
    chk("shift register", 8'(exp_sr), shift_data_register_q);
    chk("counter", 8'(exp_cnt), 8'(counter_q));
    chk("overflow flag", 8'(exp_flag), 8'(counter_overflow_flag_q));
  endtask : chk_model
  task automatic shift_count(input logic b, input int n);
    exp_sr = ((exp_sr << 1) | int'(b)) & 255;
    repeat (n) begin
      exp_cnt = (exp_cnt + 1) % 16;
      if (exp_cnt == 0) exp_flag = 1'b1;
    end
  endtask : shift_count
  task automatic wr_ctrl(input logic [1:0] m, input logic e, x, s, t);
    ctrl_wire_mode = m;
    ctrl_clock_edge_select = e;
    ctrl_external_clock_select = x;
    ctrl_software_clock_strobe = s;
    ctrl_clock_pin_toggle = t;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
    tick(1);
  endtask : wr_ctrl
  task automatic wr_data(input logic [7:0] d);
    data_wdata = d;
    data_wr = 1'b1;
    tick(1);
    data_wr = 1'b0;
    tick(1);
    exp_sr = int'(d);
  endtask : wr_data
  task automatic wr_stat(input logic oc, sc, input logic [3:0] c);
    {status_overflow_clear, status_start_clear, status_counter_wdata} = {oc, sc, c};
    status_wr = 1'b1;
    tick(1);
    status_wr = 1'b0;
    tick(1);
    exp_cnt = int'(c);
    if (oc) exp_flag = 1'b0;
  endtask : wr_stat
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #1_000_000;
    n_mismatch++;
    $display("[ERR] watchdog expected finish seen timeout");
    print_verdict();
  end

  // ****
  // test sequence
  // ****
  initial begin
    {resetn, timer_compare, ctrl_wr, ctrl_clock_edge_select, ctrl_external_clock_select} = '0;
    {ctrl_software_clock_strobe, ctrl_clock_pin_toggle, data_wr, status_wr} = '0;
    {status_overflow_clear, status_start_clear, port_clock_dir, port_data_dir} = '0;
    {overflow_int_en, start_int_en, tb_scl, tb_di, exp_clk, exp_flag} = '0;
    {ctrl_wire_mode, data_wdata, status_counter_wdata} = '0;
    tb_own = 1'b1;
    {exp_sr, exp_cnt, n_mismatch, tests_run} = '0;
    seed = $urandom(32'h2b7e3f72);
    repeat (3) @(posedge core_clk);
    #2 resetn = 1'b1;
    chk("pin enables", 8'h07, 8'({data_out_oe_n_q, sda_oe_n_q, shift_clock_oe_n_q}));
    chk_model();
    tick(5);
    wr_data(8'ha5);
    wr_stat(1'b0, 1'b0, 4'h7);
    chk_model();
    $display("test registers done");
    // pin clocked slave, three mode 0 bytes (one slow), then one mode 1 byte
    {port_data_dir, overflow_int_en, tb_own} = 3'b110;
    wr_ctrl(USU_WM_THREE, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        wr_ctrl(USU_WM_THREE, 1'b1, 1'b1, 1'b0, 1'b0);
      end
      txd = 8'($urandom);
      txm = 8'($urandom);
      wr_data(txd);
      wr_stat(1'b1, 1'b0, 4'h0); // cleared before each byte
      tick(3);
      // mode 1 shows its first bit only after the leading edge
      if (k < 3) begin
        chk("first bit", {7'h00, txd[7]}, 8'({data_out_oe_n_q, data_out_q}));
      end
      u_master.xfer(txm, (k == 1) ? 47 : 30, k == 3, rx);
      tick(10);
      for (int i = 7; i >= 0; i--) shift_count(txm[i], 2);
      chk("byte at master", txd, rx);
      chk_model();
      chk("overflow irq", 8'h01, 8'(overflow_irq_q));
    end
    wr_stat(1'b1, 1'b0, 4'h0);
    chk("irq cleared", 8'h00, 8'(overflow_irq_q));
    $display("test slave done");
    // strobe master at one bit per twelve core cycles, counter preloaded to wrap after a byte
    {overflow_int_en, tb_own} = 2'b01;
    wr_ctrl(USU_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b0);
    port_clock_dir = 1'b1;
    txm = 8'($urandom);
    wr_data(8'($urandom));
    wr_stat(1'b1, 1'b0, 4'h8);
    for (int i = 7; i >= 0; i--) begin
      tb_di = txm[i];
      tick(6);
      wr_ctrl(USU_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b1);
      exp_clk = ~exp_clk;
      chk("clock pin", 8'(exp_clk), 8'(shift_clock_out_q));
      wr_ctrl(USU_WM_THREE, 1'b0, 1'b0, 1'b1, 1'b1);
      exp_clk = ~exp_clk;
      shift_count(tb_di, 1);
      tick(2);
      chk("clock pin", 8'(exp_clk), 8'(shift_clock_out_q));
      chk_model();
      chk("data out", 8'(exp_sr[7]), 8'(data_out_q));
    end
    chk("masked irq, driver", 8'h00, 8'({overflow_irq_q, shift_clock_oe_n_q}));
    port_clock_dir = 1'b0;
    $display("test strobe master done");
    // timer source, wrap through 15, then a quiet spell
    wr_ctrl(USU_WM_THREE, 1'b1, 1'b0, 1'b0, 1'b0);
    wr_stat(1'b1, 1'b0, 4'he);
    tb_di = 1'b1;
    tick(6);
    for (int i = 0; i < 3; i++) begin
      timer_compare = 1'b1;
      tick(1);
      timer_compare = 1'b0;
      tick(2);
      shift_count(1'b1, 1);
    end
    chk_model();
    tick(20);
    chk_model();
    $display("test timer done");
    // two-wire start condition and clock hold
    {port_data_dir, start_int_en, tb_scl} = 3'b011;
    wr_ctrl(USU_WM_TWO, 1'b1, 1'b1, 1'b0, 1'b0);
    wr_stat(1'b1, 1'b1, 4'h0);
    tick(8);
    tb_di = 1'b0;
    tick(8);
    chk("start flag irq", 8'h03, 8'({start_flag_q, start_irq_q}));
    tb_scl = 1'b0;
    tick(8);
    chk("clock hold", 8'h00, 8'({shift_clock_oe_n_q, shift_clock_out_q}));
    wr_stat(1'b0, 1'b1, 4'h0);
    tick(2);
    chk("clock release", 8'h02, 8'({shift_clock_oe_n_q, start_flag_q}));
    // hold mode: a wrap on a pin edge holds the clock once it has fallen
    wr_ctrl(USU_WM_TWO_HOLD, 1'b1, 1'b1, 1'b0, 1'b0);
    wr_stat(1'b1, 1'b0, 4'hf);
    tb_scl = 1'b1;
    tick(8);
    tb_scl = 1'b0;
    tick(8);
    chk("overflow hold", 8'h01, 8'({shift_clock_oe_n_q, counter_overflow_flag_q}));
    wr_stat(1'b1, 1'b0, 4'h0);
    tick(2);
    chk("overflow release", 8'h01, 8'(shift_clock_oe_n_q));
    $display("test two-wire done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
